// ===== design/charger_otp_option_registers.sv
`timescale 1ns/1ps
module charger_otp_option_registers (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register access from the serial target
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Soft reset events
  input wire logic register_reset,
  input wire logic watchdog_expiry,
  // OTP load
  input wire logic otp_load,
  input wire logic [7:0] otp_option,
  input wire logic [7:0] otp_charge_current,
  input wire logic [7:0] otp_pre_term,
  input wire logic [5:0] otp_batt_reg,
  // Decoded settings
  output logic [3:0] discharge_limit,
  output logic system_overvolt_protect_on,
  output logic ship_entry_method,
  output logic [6:0] target_address,
  output logic low_power_allowed,
  output logic [7:0] charge_current_setting,
  output logic [3:0] precharge_current_setting,
  output logic [3:0] termination_current_setting,
  output logic [5:0] battery_regulation_voltage,
  output logic [1:0] watchdog_setting,
  output logic [3:0] system_regulation_voltage,
  output logic charge_disable,
  output logic thermistor_sense_on
);

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  function automatic logic [6:0] addr_of(input logic [1:0] sel);
    unique case (sel)
      2'h0: addr_of = charger_otp_pkg::TARGET_ADDR_0;
      2'h1: addr_of = charger_otp_pkg::TARGET_ADDR_1;
      2'h2: addr_of = charger_otp_pkg::TARGET_ADDR_2;
      2'h3: addr_of = charger_otp_pkg::TARGET_ADDR_3;
    endcase
  endfunction : addr_of

  logic [3:0] dlim_r;
  logic [7:0] opt_r;
  logic [7:0] rdata_nxt;
  wire sel_dlim = (reg_addr == charger_otp_pkg::OFF_DISCHARGE_LIMIT);
  wire sel_opt = (reg_addr == charger_otp_pkg::OFF_OTP_OPTION);
  // Only the discharge limit takes writes; option register ignores them
  wire dlim_wr = reg_wr && sel_dlim;
  // Zero code is outside the valid range; keep the old value instead
  wire dlim_code_ok = (reg_wdata[3:0] >= charger_otp_pkg::DISCHARGE_LIMIT_MIN_CODE);
  wire soft_rst = register_reset || watchdog_expiry;
  // Unused option bits are forced to zero whatever the fuses hold
  wire [7:0] opt_masked = otp_option & charger_otp_pkg::OPT_USED_MASK;
  wire [7:0] dlim_view = {4'h0, dlim_r};

  always_comb begin
    rdata_nxt = 8'h00;
    if (sel_dlim) begin
      rdata_nxt = dlim_view;
    end else if (sel_opt) begin
      rdata_nxt = opt_r;
    end
  end

  // ---------------------------------------------------------------
  // Discharge limit register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dlim_r <= charger_otp_pkg::DISCHARGE_LIMIT_POR;
    end else if (soft_rst) begin
      dlim_r <= charger_otp_pkg::DISCHARGE_LIMIT_POR;
    end else if (dlim_wr && dlim_code_ok) begin
      dlim_r <= reg_wdata[charger_otp_pkg::DISCHARGE_LIMIT_MSB:0];
    end
  end

  // ---------------------------------------------------------------
  // OTP shadow registers
  // ---------------------------------------------------------------
  // Fuse values enter only on the load strobe, so no host write reaches them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      opt_r <= charger_otp_pkg::OTP_OPTION_DEFAULT;
    end else if (otp_load) begin
      opt_r <= opt_masked;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      charge_current_setting <= charger_otp_pkg::CHARGE_CURRENT_DEFAULT;
    end else if (otp_load) begin
      charge_current_setting <= otp_charge_current;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      precharge_current_setting <= charger_otp_pkg::PRECHARGE_DEFAULT;
    end else if (otp_load) begin
      precharge_current_setting <= otp_pre_term[7:4];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      termination_current_setting <= charger_otp_pkg::TERMINATION_DEFAULT;
    end else if (otp_load) begin
      termination_current_setting <= otp_pre_term[3:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      battery_regulation_voltage <= charger_otp_pkg::BATT_REG_DEFAULT;
    end else if (otp_load) begin
      battery_regulation_voltage <= otp_batt_reg;
    end
  end

  // ---------------------------------------------------------------
  // Fixed settings
  // ---------------------------------------------------------------
  // No fuse input reaches these here; they keep their power-up defaults
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_setting <= charger_otp_pkg::WATCHDOG_DEFAULT;
      system_regulation_voltage <= charger_otp_pkg::SYS_REG_DEFAULT;
    end
  end

  // Charging stays enabled and thermistor sensing off until a fuse path exists
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      charge_disable <= 1'b0;
      thermistor_sense_on <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Option field decode
  // ---------------------------------------------------------------
  wire ovp_nxt = opt_r[charger_otp_pkg::OPT_SYSOVP_BIT];
  wire ship_nxt = opt_r[charger_otp_pkg::OPT_SHIP_BIT];
  wire [1:0] addr_sel = opt_r[charger_otp_pkg::OPT_ADDR_MSB:charger_otp_pkg::OPT_ADDR_LSB];
  wire [6:0] target_nxt = addr_of(addr_sel);
  // Fuse bit is set for not available, the output is high for available
  wire low_power_nxt = !opt_r[charger_otp_pkg::OPT_LOWPWR_BIT];

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  // Every output below is a registered copy, one cycle behind its source; reg_rdata loads only while reg_rd is high
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      discharge_limit <= charger_otp_pkg::DISCHARGE_LIMIT_POR;
    end else begin
      discharge_limit <= dlim_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      system_overvolt_protect_on <= 1'b0;
    end else begin
      system_overvolt_protect_on <= ovp_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ship_entry_method <= 1'b0;
    end else begin
      ship_entry_method <= ship_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      target_address <= charger_otp_pkg::TARGET_ADDR_0;
    end else begin
      target_address <= target_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_power_allowed <= 1'b1;
    end else begin
      low_power_allowed <= low_power_nxt;
    end
  end

endmodule : charger_otp_option_registers

// ===== design/charger_otp_pkg.sv
package charger_otp_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_DISCHARGE_LIMIT = 8'h0d;
  localparam logic [7:0] OFF_OTP_OPTION = 8'h0e;

  // ---------------------------------------------------------------
  // Discharge limit field
  // ---------------------------------------------------------------
  localparam int DISCHARGE_LIMIT_MSB = 3;
  localparam int DISCHARGE_LIMIT_W = 4;
  localparam logic [3:0] DISCHARGE_LIMIT_POR = 4'h9;
  localparam logic [3:0] DISCHARGE_LIMIT_MIN_CODE = 4'h1;
  localparam int DISCHARGE_OFFSET_MA = 200;
  localparam int DISCHARGE_STEP_MA = 200;

  // ---------------------------------------------------------------
  // Option register bit positions
  // ---------------------------------------------------------------
  localparam int OPT_SYSOVP_BIT = 7;
  localparam int OPT_SHIP_BIT = 5;
  localparam int OPT_ADDR_MSB = 4;
  localparam int OPT_ADDR_LSB = 3;
  localparam int OPT_LOWPWR_BIT = 2;
  localparam logic [7:0] OPT_USED_MASK = 8'hbc;

  // ---------------------------------------------------------------
  // Target address codes
  // ---------------------------------------------------------------
  localparam logic [6:0] TARGET_ADDR_0 = 7'h08;
  localparam logic [6:0] TARGET_ADDR_1 = 7'h0a;
  localparam logic [6:0] TARGET_ADDR_2 = 7'h0c;
  localparam logic [6:0] TARGET_ADDR_3 = 7'h0e;

  // ---------------------------------------------------------------
  // OTP map defaults (raw codes)
  // ---------------------------------------------------------------
  localparam logic [7:0] OTP_OPTION_DEFAULT = 8'h00;
  // 128mA = 8mA + 60 * 2mA
  localparam logic [7:0] CHARGE_CURRENT_DEFAULT = 8'h3c;
  // 3mA = 1mA + 1 * 2mA
  localparam logic [3:0] PRECHARGE_DEFAULT = 4'h1;
  localparam logic [3:0] TERMINATION_DEFAULT = 4'h1;
  // 4.2V = 3.6V + 40 * 15mV
  localparam logic [5:0] BATT_REG_DEFAULT = 6'h28;
  localparam logic [1:0] WATCHDOG_DEFAULT = 2'h1;
  // 4.65V code above the 50mV/step base
  localparam logic [3:0] SYS_REG_DEFAULT = 4'h5;

endpackage : charger_otp_pkg

// ===== verification/charger_host_model.sv
`timescale 1ns/1ps
module charger_host_model (
  // Clock and read data
  input wire logic ref_clk,
  input wire logic [7:0] reg_rdata,
  // Register requests
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0;
  // Released lines show the inverse so a stale value never passes for a live one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge ref_clk);
    {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge ref_clk);
    d = reg_rdata;
    {reg_addr, reg_rd} = {~a, 1'b0};
  endtask : rd
endmodule : charger_host_model

// ===== verification/charger_otp_option_registers_bench.sv
`timescale 1ns/1ps
module charger_otp_option_registers_bench;
  logic ref_clk = 0, rst_n = 0, register_reset = 0, watchdog_expiry = 0, otp_load = 0;
  logic reg_wr, reg_rd, system_overvolt_protect_on, ship_entry_method, low_power_allowed;
  logic charge_disable, thermistor_sense_on;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v, charge_current_setting;
  logic [7:0] otp_option = 0, otp_charge_current = 0, otp_pre_term = 0;
  logic [5:0] otp_batt_reg = 0, battery_regulation_voltage;
  logic [6:0] target_address;
  logic [3:0] discharge_limit, precharge_current_setting, termination_current_setting;
  logic [3:0] system_regulation_voltage;
  logic [1:0] watchdog_setting;
  logic [31:0] seed = 32'h00015068;
  int failures = 0, total_checks = 0, cyc = 0, limit_m = 9;
  charger_host_model host_u (.*);
  charger_otp_option_registers dut_u (.*);
  initial forever #20 ref_clk = ~ref_clk;
  // Ceiling is well above the fewer than one hundred cycles the sequence needs
  always @(posedge ref_clk) if (++cyc == 2000) begin failures++; final_report(); end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  initial begin
    repeat (12) @(negedge ref_clk);
    rst_n = 1;
    chk("limit", discharge_limit, 4'h9);
    chk("defaults", {charge_current_setting, precharge_current_setting, termination_current_setting,
      battery_regulation_voltage, watchdog_setting, system_regulation_voltage, charge_disable,
      thermistor_sense_on}, {8'h3c, 4'h1, 4'h1, 6'h28, 2'h1, 4'h5, 2'h0});
    chk("options", {system_overvolt_protect_on, ship_entry_method, target_address, low_power_allowed},
      {2'h0, 7'h08, 1'b1});
    host_u.rd(8'h0e, v);
    chk("option default", v, 8'h00);
    $display("test reset done");
    // The first pass writes code zero with upper bits set, which must be dropped
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 8'hf0 : 8'(xs());
      host_u.wr(8'h0d, v);
      if (v[3:0] != 4'h0) limit_m = v[3:0];
      host_u.rd(8'h0d, v);
      chk("limit read", v, limit_m);
      chk("limit", discharge_limit, limit_m);
    end
    host_u.wr(8'h0e, 8'hff);
    host_u.rd(8'h0e, v);
    chk("option write", v, 8'h00);
    $display("test limit done");
    for (int k = 0; k < 2; k++) begin
      host_u.wr(8'h0d, 8'h03);
      {register_reset, watchdog_expiry} = k ? 2'b01 : 2'b10;
      @(negedge ref_clk);
      {register_reset, watchdog_expiry} = 2'b00;
      host_u.rd(8'h0d, v);
      chk("limit soft reset", v, 9);
    end
    $display("test soft reset done");
    for (int k = 0; k < 4; k++) begin
      {otp_option, otp_charge_current, otp_pre_term, otp_batt_reg} = 30'(xs());
      otp_option[4:3] = 2'(k);
      otp_load = 1;
      fork
        host_u.rd(8'h0e, v);
        @(negedge ref_clk) otp_load = 0;
      join
      chk("option read", v, otp_option & 8'hbc);
      chk("decoded", {system_overvolt_protect_on, ship_entry_method, target_address,
        low_power_allowed}, {otp_option[7], otp_option[5], 7'(8 + 2 * k), !otp_option[2]});
      chk("otp", {charge_current_setting, precharge_current_setting, termination_current_setting,
        battery_regulation_voltage}, {otp_charge_current, otp_pre_term, otp_batt_reg});
    end
    $display("test otp done");
    rst_n = 0;
    @(negedge ref_clk);
    chk("limit in reset", discharge_limit, 4'h9);
    @(negedge ref_clk);
    rst_n = 1;
    host_u.rd(8'h0e, v);
    chk("option after reset", v, 8'h00);
    chk("address after reset", target_address, 7'h08);
    host_u.wr(8'h0d, 8'h05);
    host_u.rd(8'h0d, v);
    chk("limit after reset", v, 8'h05);
    $display("test second reset done");
    final_report();
  end
endmodule : charger_otp_option_registers_bench

// ===== verification/charger_otp_option_registers_monitor.sv
`timescale 1ns/1ps
module charger_otp_option_registers_monitor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port and events
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic register_reset,
  input wire logic watchdog_expiry,
  input wire logic otp_load,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] otp_option,
  // Decoded settings
  input wire logic [3:0] discharge_limit,
  input wire logic [6:0] target_address,
  input wire logic system_overvolt_protect_on,
  input wire logic ship_entry_method,
  input wire logic low_power_allowed
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire soft_evt = register_reset | watchdog_expiry;
  a_limit_write: assert property (reg_wr && reg_addr == 8'h0d && reg_wdata[3:0] != 4'h0 && !soft_evt
    |-> ##2 discharge_limit == $past(reg_wdata[3:0], 2)) else $error("limit write lost");
  a_limit_reset: assert property (soft_evt |-> ##2 discharge_limit == 4'h9)
    else $error("limit not reset");
  a_upper_zero: assert property (reg_rd && reg_addr == 8'h0d |=> reg_rdata[7:4] == 4'h0)
    else $error("upper bits set");
  a_option_read: assert property (otp_load ##1 (reg_rd && reg_addr == 8'h0e)
    |=> reg_rdata == ($past(otp_option, 2) & 8'hbc)) else $error("option read wrong");
  a_ovp_follow: assert property (otp_load |-> ##2 system_overvolt_protect_on == $past(otp_option[7], 2))
    else $error("ovp wrong");
  a_ship_follow: assert property (otp_load |-> ##2 ship_entry_method == $past(otp_option[5], 2))
    else $error("ship wrong");
  a_target_map: assert property (otp_load
    |-> ##2 target_address == 7'h08 + {$past(otp_option[4:3], 2), 1'b0}) else $error("address wrong");
  a_low_power: assert property (otp_load |-> ##2 low_power_allowed == !$past(otp_option[2], 2))
    else $error("low power wrong");
endmodule : charger_otp_option_registers_monitor
bind charger_otp_option_registers charger_otp_option_registers_monitor mon_u (.*);
